//--- rtl/rtf_map.svh
// offsets, field positions and reset values of the test register file
// assumes byte offsets are formed as the word index times four
`ifndef RTF_MAP_SVH
`define RTF_MAP_SVH

// channel count of the striping array
`define RTF_CHANNELS 2

// write-only parameter registers (byte offsets)
`define RTF_OFS_START_LO 17'h00000
`define RTF_OFS_START_HI 17'h00004
`define RTF_OFS_COUNT_LO 17'h00008
`define RTF_OFS_COUNT_HI 17'h0000C
`define RTF_OFS_COMMAND 17'h00010
`define RTF_OFS_PATTERN 17'h00014
`define RTF_OFS_TIMEOUT 17'h00020

// read-only status registers (byte offsets)
`define RTF_OFS_STATE 17'h00100
`define RTF_OFS_CAP_LO 17'h00104
`define RTF_OFS_CAP_HI 17'h00108
`define RTF_OFS_ERR0 17'h00110
`define RTF_OFS_ERR1 17'h00114
`define RTF_OFS_LINK0 17'h00120
`define RTF_OFS_LINK1 17'h00124
`define RTF_OFS_COMP0 17'h00130
`define RTF_OFS_COMP1 17'h00134
`define RTF_OFS_CAPW0 17'h00140
`define RTF_OFS_CAPW1 17'h00144
`define RTF_OFS_DBG0 17'h00150
`define RTF_OFS_DBG1 17'h00154

// area decode: (address & mask) == base
`define RTF_MASK_256 17'h1FF00
`define RTF_MASK_4K 17'h1F000
`define RTF_MASK_32K 17'h18000
`define RTF_BASE_CMD 17'h00000
`define RTF_BASE_STAT 17'h00100
`define RTF_BASE_CSUB 17'h00400
`define RTF_BASE_CCOMP 17'h00500
`define RTF_BASE_TEST 17'h01000
`define RTF_BASE_IDENT 17'h10000
`define RTF_BASE_CDATA 17'h18000

// field positions
`define RTF_HI_W 16
`define RTF_CODE_W 3
`define RTF_ST_BUSY 0
`define RTF_ST_ERROR 1
`define RTF_ST_VFAIL 2
`define RTF_CAP_MODE 31
`define RTF_LNK_UP 0
`define RTF_LNK_SPD 2
`define RTF_LNK_WIDTH 4
`define RTF_LNK_LTSSM 8
`define RTF_LNK_SPD_MSB 16
`define RTF_COMP_IO 16

// command codes
`define RTF_CMD_IDENTIFY 3'h0
`define RTF_CMD_SHUTDOWN 3'h1
`define RTF_CMD_WRITE 3'h2
`define RTF_CMD_READ 3'h3
`define RTF_CMD_SMART 3'h4
`define RTF_CMD_RSVD5 3'h5
`define RTF_CMD_FLUSH 3'h6
`define RTF_CMD_RSVD7 3'h7

// test pattern codes
`define RTF_PAT_INC 3'h0
`define RTF_PAT_DEC 3'h1
`define RTF_PAT_ZERO 3'h2
`define RTF_PAT_ONE 3'h3
`define RTF_PAT_LFSR 3'h4

// reset and idle values
`define RTF_ZERO_WORD 32'h00000000

`endif

//--- rtl/rtf_pkg.sv
// types shared by the test register file and its read path
// assumes rtf_map.svh is on the include path
package rtf_pkg;
`include "rtf_map.svh"

	// read return source chosen by the upper index bits
	typedef enum logic [2:0] {
		RTF_AREA_NONE = 3'b000,
		RTF_AREA_STAT = 3'b001,
		RTF_AREA_CCOMP = 3'b010,
		RTF_AREA_TEST = 3'b011,
		RTF_AREA_IDENT = 3'b100,
		RTF_AREA_CDATA = 3'b101
	} rtf_area_t;

	// command codes toward the striping core
	typedef enum logic [2:0] {
		RTF_CMD_IDENTIFY_C = `RTF_CMD_IDENTIFY,
		RTF_CMD_SHUTDOWN_C = `RTF_CMD_SHUTDOWN,
		RTF_CMD_WRITE_C = `RTF_CMD_WRITE,
		RTF_CMD_READ_C = `RTF_CMD_READ,
		RTF_CMD_SMART_C = `RTF_CMD_SMART,
		RTF_CMD_RSVD5_C = `RTF_CMD_RSVD5,
		RTF_CMD_FLUSH_C = `RTF_CMD_FLUSH,
		RTF_CMD_RSVD7_C = `RTF_CMD_RSVD7
	} rtf_cmd_t;

	// data patterns of the tester
	typedef enum logic [2:0] {
		RTF_PAT_INC_C = `RTF_PAT_INC,
		RTF_PAT_DEC_C = `RTF_PAT_DEC,
		RTF_PAT_ZERO_C = `RTF_PAT_ZERO,
		RTF_PAT_ONE_C = `RTF_PAT_ONE,
		RTF_PAT_LFSR_C = `RTF_PAT_LFSR
	} rtf_pattern_t;

	// whole state of the register file
	typedef struct packed {
		logic [31:0] start_lo;
		logic [15:0] start_hi;
		logic [31:0] count_lo;
		logic [15:0] count_hi;
		rtf_cmd_t cmd;
		logic cmd_req;
		rtf_pattern_t pattern;
		logic [31:0] timeout;
		logic [12:0] buf_index;
		logic [31:0] buf_word;
		logic csub_wr;
		logic cdata_wr;
		logic rd_req;
		rtf_area_t rd_area;
		logic [31:0] rd_local;
	} rtf_top_state_t;

	// whole state of the read path
	typedef struct packed {
		logic req;
		rtf_area_t area;
		logic [31:0] local_word;
		logic valid;
		logic [31:0] word;
	} rtf_rd_state_t;

endpackage

//--- rtl/rtf_rd_if.sv
// read request and return between the register file and its read path
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface rtf_rd_if;
	import rtf_pkg::*;

	// first pipeline stage, from the register file
	logic req;
	rtf_area_t area;
	logic [31:0] local_word;
	// submodule words answering the lower index bits
	logic [31:0] ccomp_word;
	logic [31:0] test_word;
	logic [31:0] ident_word;
	logic [31:0] cdata_word;
	// final return
	logic valid;
	logic [31:0] word;

	modport front (
		output req, area, local_word, ccomp_word, test_word, ident_word, cdata_word,
		input valid, word
	);
	modport back (
		input req, area, local_word, ccomp_word, test_word, ident_word, cdata_word,
		output valid, word
	);
endinterface

//--- rtl/rtf_read_path.sv
// second and third read stages: final multiplexer and return flag
// assumes submodule words are valid two edges after the request edge
`timescale 1ns/1ps
`include "rtf_map.svh"
module rtf_read_path (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// stage one in, return out
	rtf_rd_if.back rd
);
	import rtf_pkg::*;

	rtf_rd_state_t state;
	rtf_rd_state_t next_state;

	// stage two holds the source, stage three picks the word
	always_comb
	begin
		next_state = state;
		next_state.req = rd.req;
		next_state.area = rd.area;
		next_state.local_word = rd.local_word;
		next_state.valid = state.req;
		if (state.req)
		begin
			case (state.area)
				RTF_AREA_STAT: next_state.word = state.local_word;
				RTF_AREA_CCOMP: next_state.word = rd.ccomp_word;
				RTF_AREA_TEST: next_state.word = rd.test_word;
				RTF_AREA_IDENT: next_state.word = rd.ident_word;
				RTF_AREA_CDATA: next_state.word = rd.cdata_word;
				default: next_state.word = `RTF_ZERO_WORD;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			state <= '0;
		else
			state <= next_state;
	end

	assign rd.valid = state.valid;
	assign rd.word = state.word;
endmodule

//--- rtl/rtf_register_file.sv
// register file, address decoder and read multiplexer of the striping test system
// assumes a word-indexed register port in the same clock domain as the striping core
`timescale 1ns/1ps
`include "rtf_map.svh"

// Operation
// - offsets 0x00000-0x000FF hold write-only command and parameter registers
// - offsets 0x00400-0x004FF are write-only custom command parameters
// - offsets 0x00100-0x001FF read back striping core status
// - offsets 0x00500-0x005FF read custom command completion status
// - offsets 0x01000-0x01FFF read pattern tester status
// - offsets 0x10000-0x17FFF read the identify buffer
// - offsets 0x18000-0x1FFFF write and read the custom data buffer
// - upper index bits choose unit and return source, lower bits go to submodules
// - every write updates the full word, byte lane mask ignored
// - read returns after three cycles, flag is request through three flops
// - start sector is 48 bits from low word and high bits 15:0
// - sector count is 48 bits from low word and high bits 15:0
// - command codes: identify, shutdown, write, read, smart/erase, flush, two reserved
// - writing the command register also pulses a command request
// - pattern select picks increment, decrement, zeros, ones or LFSR data
// - one timeout word drives both channels
// - status bits: busy 0, error 1, verify failure 2
// - capacity low word, high bits 15:0, addressing flag bit 31
// - channel error codes at 0x110 and 0x114
// - link word: linkup, speed 3:2 plus bit 16, width 6:4, state 13:8
// - completion word: admin code low half, io code high half
// - capability words at 0x140/0x144, debug words at 0x150/0x154
module rtf_register_file (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// register port
	input wire logic [14:0] register_index_in,
	input wire logic write_strobe_in,
	input wire logic [31:0] write_word_in,
	input wire logic [3:0] byte_lane_mask_in,
	input wire logic read_request_pulse_in,
	output logic read_return_flag_out,
	output logic [31:0] read_return_word_out,
	// striping core and tester parameters
	output logic [47:0] start_sector_out,
	output logic [47:0] sector_count_out,
	output rtf_pkg::rtf_cmd_t host_command_code_out,
	output logic command_request_out,
	output rtf_pkg::rtf_pattern_t pattern_select_out,
	output logic [31:0] command_timeout_value_out,
	// queue and buffer access
	output logic [12:0] buffer_index_out,
	output logic [31:0] buffer_word_out,
	output logic custom_submission_write_out,
	output logic custom_data_write_out,
	input wire logic [31:0] custom_completion_word_in,
	input wire logic [31:0] tester_status_word_in,
	input wire logic [31:0] identify_word_in,
	input wire logic [31:0] custom_data_word_in,
	// array status
	input wire logic array_busy_flag_in,
	input wire logic array_error_flag_in,
	input wire logic verify_fail_in,
	input wire logic [47:0] total_capacity_in,
	input wire logic capacity_addressing_flag_in,
	// per-channel status
	input wire logic [1:0][31:0] channel_error_code_in,
	input wire logic [1:0] linkup_in,
	input wire logic [1:0][2:0] link_speed_in,
	input wire logic [1:0][2:0] link_width_in,
	input wire logic [1:0][5:0] ltssm_state_in,
	input wire logic [1:0][15:0] admin_completion_code_in,
	input wire logic [1:0][15:0] io_completion_code_in,
	input wire logic [1:0][31:0] controller_capability_word_in,
	input wire logic [1:0][31:0] channel_debug_word_in
);
	import rtf_pkg::*;

	rtf_top_state_t state;
	rtf_top_state_t next_state;
	logic [16:0] byte_addr;
	logic [1:0][31:0] link_word;
	logic [1:0][31:0] comp_word;
	logic [31:0] status_word;
	logic [31:0] state_word;
	logic [31:0] cap_hi_word;
	rtf_area_t read_area;
	logic in_cmd_area;
	logic in_csub_area;
	logic in_cdata_area;

	rtf_rd_if rd_bus ();

	// map a byte address to its read source
	function automatic rtf_area_t area_of(input logic [16:0] a);
		rtf_area_t r;
		r = RTF_AREA_NONE;
		if ((a & `RTF_MASK_256) == `RTF_BASE_STAT)
			r = RTF_AREA_STAT;
		else if ((a & `RTF_MASK_256) == `RTF_BASE_CCOMP)
			r = RTF_AREA_CCOMP;
		else if ((a & `RTF_MASK_4K) == `RTF_BASE_TEST)
			r = RTF_AREA_TEST;
		else if ((a & `RTF_MASK_32K) == `RTF_BASE_IDENT)
			r = RTF_AREA_IDENT;
		else if ((a & `RTF_MASK_32K) == `RTF_BASE_CDATA)
			r = RTF_AREA_CDATA;
		return r;
	endfunction

	// word index to byte address
	assign byte_addr = {register_index_in, 2'h0};

	// write-side area decode
	// upper bits select unit
	assign in_cmd_area = (byte_addr & `RTF_MASK_256) == `RTF_BASE_CMD;
	assign in_csub_area = (byte_addr & `RTF_MASK_256) == `RTF_BASE_CSUB;
	assign in_cdata_area = (byte_addr & `RTF_MASK_32K) == `RTF_BASE_CDATA;
	assign read_area = area_of(byte_addr);

	// per-channel link and completion words
	for (genvar ch = 0; ch < `RTF_CHANNELS; ch++)
	begin : g_chan
		always_comb
		begin
			link_word[ch] = `RTF_ZERO_WORD;
			link_word[ch][`RTF_LNK_UP] = linkup_in[ch];
			link_word[ch][`RTF_LNK_SPD +: 2] = link_speed_in[ch][1:0];
			link_word[ch][`RTF_LNK_WIDTH +: 3] = link_width_in[ch];
			link_word[ch][`RTF_LNK_LTSSM +: 6] = ltssm_state_in[ch];
			link_word[ch][`RTF_LNK_SPD_MSB] = link_speed_in[ch][2];
		end
		always_comb
		begin
			comp_word[ch] = `RTF_ZERO_WORD;
			comp_word[ch][0 +: `RTF_HI_W] = admin_completion_code_in[ch];
			comp_word[ch][`RTF_COMP_IO +: `RTF_HI_W] = io_completion_code_in[ch];
		end
	end

	// array status and capacity high words
	always_comb
	begin
		state_word = `RTF_ZERO_WORD;
		cap_hi_word = `RTF_ZERO_WORD;
		state_word[`RTF_ST_BUSY] = array_busy_flag_in;
		state_word[`RTF_ST_ERROR] = array_error_flag_in;
		state_word[`RTF_ST_VFAIL] = verify_fail_in;
		cap_hi_word[0 +: `RTF_HI_W] = total_capacity_in[47:32];
		cap_hi_word[`RTF_CAP_MODE] = capacity_addressing_flag_in;
	end

	// first-level mux over the core status area
	always_comb
	begin
		case (byte_addr)
			`RTF_OFS_STATE: status_word = state_word;
			`RTF_OFS_CAP_LO: status_word = total_capacity_in[31:0];
			`RTF_OFS_CAP_HI: status_word = cap_hi_word;
			`RTF_OFS_ERR0: status_word = channel_error_code_in[0];
			`RTF_OFS_ERR1: status_word = channel_error_code_in[1];
			`RTF_OFS_LINK0: status_word = link_word[0];
			`RTF_OFS_LINK1: status_word = link_word[1];
			`RTF_OFS_COMP0: status_word = comp_word[0];
			`RTF_OFS_COMP1: status_word = comp_word[1];
			`RTF_OFS_CAPW0: status_word = controller_capability_word_in[0];
			`RTF_OFS_CAPW1: status_word = controller_capability_word_in[1];
			`RTF_OFS_DBG0: status_word = channel_debug_word_in[0];
			`RTF_OFS_DBG1: status_word = channel_debug_word_in[1];
			// holes in the area read zero
			default: status_word = `RTF_ZERO_WORD;
		endcase
	end

	// next state: parameter writes, strobes and first read stage
	always_comb
	begin
		next_state = state;
		next_state.cmd_req = 1'b0;
		next_state.csub_wr = 1'b0;
		next_state.cdata_wr = 1'b0;
		if (write_strobe_in)
		begin
			next_state.buf_word = write_word_in;
			next_state.buf_index = register_index_in[12:0];
			if (in_cmd_area)
			begin
				case (byte_addr)
					`RTF_OFS_START_LO: next_state.start_lo = write_word_in;
					`RTF_OFS_START_HI: next_state.start_hi = write_word_in[`RTF_HI_W-1:0];
					`RTF_OFS_COUNT_LO: next_state.count_lo = write_word_in;
					`RTF_OFS_COUNT_HI: next_state.count_hi = write_word_in[`RTF_HI_W-1:0];
					`RTF_OFS_COMMAND:
					begin
						next_state.cmd = rtf_cmd_t'(write_word_in[`RTF_CODE_W-1:0]);
						next_state.cmd_req = 1'b1;
					end
					`RTF_OFS_PATTERN: next_state.pattern = rtf_pattern_t'(write_word_in[`RTF_CODE_W-1:0]);
					`RTF_OFS_TIMEOUT: next_state.timeout = write_word_in;
					default: next_state.timeout = state.timeout;
				endcase
			end
			next_state.csub_wr = in_csub_area;
			next_state.cdata_wr = in_cdata_area;
		end
		next_state.rd_req = read_request_pulse_in;
		if (read_request_pulse_in)
		begin
			next_state.buf_index = register_index_in[12:0];
			next_state.rd_area = read_area;
			next_state.rd_local = status_word;
		end
	end

	// state register
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			state <= '0;
		else
			state <= next_state;
	end

	// stage one toward the read path
	assign rd_bus.req = state.rd_req;
	assign rd_bus.area = state.rd_area;
	assign rd_bus.local_word = state.rd_local;
	assign rd_bus.ccomp_word = custom_completion_word_in;
	assign rd_bus.test_word = tester_status_word_in;
	assign rd_bus.ident_word = identify_word_in;
	assign rd_bus.cdata_word = custom_data_word_in;

	// stages two and three
	rtf_read_path u_read_path (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.rd(rd_bus.back)
	);

	// outputs, all from flops
	assign read_return_flag_out = rd_bus.valid;
	assign read_return_word_out = rd_bus.word;
	assign start_sector_out = {state.start_hi, state.start_lo};
	assign sector_count_out = {state.count_hi, state.count_lo};
	assign host_command_code_out = state.cmd;
	assign command_request_out = state.cmd_req;
	assign pattern_select_out = state.pattern;
	assign command_timeout_value_out = state.timeout;
	assign buffer_index_out = state.buf_index;
	assign buffer_word_out = state.buf_word;
	assign custom_submission_write_out = state.csub_wr;
	assign custom_data_write_out = state.cdata_wr;
endmodule

//--- testbench/rtf_register_file_chk.sv
// checker of read latency and write decode of the register file
// assumes it is bound to rtf_register_file, one clock domain
`timescale 1ns/1ps
module rtf_register_file_chk (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// register port
	input wire logic [14:0] register_index_in,
	input wire logic write_strobe_in,
	input wire logic [31:0] write_word_in,
	input wire logic read_request_pulse_in,
	input wire logic read_return_flag_out,
	// parameter outputs
	input wire logic [47:0] start_sector_out,
	input wire logic [47:0] sector_count_out,
	input wire rtf_pkg::rtf_cmd_t host_command_code_out,
	input wire logic command_request_out,
	input wire logic [31:0] command_timeout_value_out,
	input wire logic custom_submission_write_out,
	input wire logic custom_data_write_out
);
	import rtf_pkg::*;
	logic wr_cmd;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// write aimed at the command register
	assign wr_cmd = write_strobe_in && register_index_in == 15'h0004;

	// read return timing
	a_ret_three_late:
	assert property (read_request_pulse_in |-> ##3 read_return_flag_out) else $error("late read return");
	a_ret_has_cause:
	assert property (read_return_flag_out |-> $past(read_request_pulse_in, 3)) else $error("stray read return");
	// command issue
	a_cmd_req_pulse:
	assert property (wr_cmd |=> command_request_out) else $error("no command request");
	a_cmd_req_cause:
	assert property (command_request_out |-> $past(wr_cmd)) else $error("stray command request");
	a_cmd_code_taken:
	assert property (wr_cmd |=> host_command_code_out == $past(write_word_in[2:0])) else $error("bad command code");
	// parameter words
	a_start_low_word:
	assert property (write_strobe_in && register_index_in == 15'h0000 |=>
		start_sector_out[31:0] == $past(write_word_in)) else $error("bad start sector");
	a_count_high_bits:
	assert property (write_strobe_in && register_index_in == 15'h0003 |=>
		sector_count_out[47:32] == $past(write_word_in[15:0])) else $error("bad sector count");
	a_timeout_full_word:
	assert property (write_strobe_in && register_index_in == 15'h0008 |=>
		command_timeout_value_out == $past(write_word_in)) else $error("bad timeout");
	a_ro_write_ignored:
	assert property (write_strobe_in && register_index_in[14:6] == 9'h001 |=> $stable(start_sector_out)
		&& $stable(sector_count_out) && $stable(command_timeout_value_out)) else $error("status write took effect");
	// buffer write strobes
	a_queue_write_hit:
	assert property (custom_submission_write_out |-> $past(write_strobe_in && register_index_in[14:6] == 9'h004))
		else $error("stray queue write");
	a_data_write_hit:
	assert property (custom_data_write_out |-> $past(write_strobe_in && register_index_in[14:13] == 2'h3))
		else $error("stray data write");

	// main scenarios
	c_cmd_issue: cover property (wr_cmd);
	c_read_done: cover property (read_return_flag_out);
	c_data_write: cover property (custom_data_write_out);
endmodule

//--- testbench/rtf_conv_model.sv
// register port driver standing for the clock-crossing converter
// assumes the register file samples on the rising clock edge
`timescale 1ns/1ps
module rtf_conv_model (
	// clock
	input wire logic sys_clk_in,
	// register port toward the register file
	output logic [14:0] index_out,
	output logic strobe_out,
	output logic [31:0] word_out,
	output logic [3:0] mask_out,
	output logic req_out,
	// read return
	input wire logic flag_in,
	input wire logic [31:0] data_in
);
	// idle port at time zero
	initial
	begin
		index_out = 15'h0000;
		strobe_out = 1'h0;
		word_out = 32'h00000000;
		mask_out = 4'h0;
		req_out = 1'h0;
	end

	// one write cycle, byte address in
	task automatic wr(input logic [16:0] a, input logic [31:0] d, input logic [3:0] m);
		@(negedge sys_clk_in);
		// one-cycle strobe with index, word and mask
		index_out = a[16:2];
		word_out = d;
		mask_out = m;
		strobe_out = 1'h1;
		@(negedge sys_clk_in);
		strobe_out = 1'h0;
		word_out = ~d; // released data no longer valid
	endtask

	// one read, word taken at the edge that sees the flag
	task automatic rd(input logic [16:0] a, output logic [31:0] d, output bit ok);
		int n;
		@(negedge sys_clk_in);
		// request pulse, index held until the return
		index_out = a[16:2];
		req_out = 1'h1;
		@(negedge sys_clk_in);
		req_out = 1'h0;
		ok = 0;
		for (n = 0; n < 8 && !ok; n++)
		begin
			@(posedge sys_clk_in);
			ok = flag_in;
		end
		d = data_in;
	endtask
endmodule

//--- testbench/rtf_register_file_tb.sv
// self-checking bench of the striping test register file
// assumes design, package, checker and converter model compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module rtf_register_file_tb;
	import rtf_pkg::*;
	int num_errors = 0;
	int num_checks = 0;
	int seed = 1;
	logic sys_clk_in, rst_in, write_strobe_in, read_request_pulse_in, read_return_flag_out, command_request_out;
	logic [31:0] write_word_in, read_return_word_out, command_timeout_value_out, buffer_word_out, w, got;
	logic [31:0] custom_completion_word_in, tester_status_word_in, identify_word_in, custom_data_word_in;
	logic [3:0] byte_lane_mask_in;
	logic [14:0] register_index_in;
	logic [47:0] start_sector_out, sector_count_out, total_capacity_in, keep;
	rtf_cmd_t host_command_code_out;
	rtf_pattern_t pattern_select_out;
	logic custom_submission_write_out, custom_data_write_out;
	logic [12:0] buffer_index_out;
	logic array_busy_flag_in, array_error_flag_in, verify_fail_in, capacity_addressing_flag_in;
	logic [1:0] linkup_in;
	logic [1:0][31:0] channel_error_code_in, controller_capability_word_in, channel_debug_word_in;
	logic [1:0][2:0] link_speed_in, link_width_in;
	logic [1:0][5:0] ltssm_state_in;
	logic [1:0][15:0] admin_completion_code_in, io_completion_code_in;
	logic [511:0] big;
	bit ok;

	// design and converter
	rtf_register_file i_rtf_register_file (.sys_clk_in, .rst_in, .register_index_in, .write_strobe_in,
		.write_word_in, .byte_lane_mask_in, .read_request_pulse_in, .read_return_flag_out, .read_return_word_out,
		.start_sector_out, .sector_count_out, .host_command_code_out, .command_request_out, .pattern_select_out,
		.command_timeout_value_out, .buffer_index_out, .buffer_word_out, .custom_submission_write_out,
		.custom_data_write_out, .custom_completion_word_in, .tester_status_word_in, .identify_word_in,
		.custom_data_word_in, .array_busy_flag_in, .array_error_flag_in, .verify_fail_in, .total_capacity_in,
		.capacity_addressing_flag_in, .channel_error_code_in, .linkup_in, .link_speed_in, .link_width_in,
		.ltssm_state_in, .admin_completion_code_in, .io_completion_code_in, .controller_capability_word_in,
		.channel_debug_word_in);
	rtf_conv_model i_rtf_conv_model (.sys_clk_in, .index_out(register_index_in), .strobe_out(write_strobe_in),
		.word_out(write_word_in), .mask_out(byte_lane_mask_in), .req_out(read_request_pulse_in),
		.flag_in(read_return_flag_out), .data_in(read_return_word_out));

	// 50 MHz clock
	initial
	begin
		sys_clk_in = 1'h0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end

	// counts, verdict and end of run
	task print_verdict;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// fresh random status and submodule words
	task automatic shake;
		for (int i = 0; i < 16; i++)
			big = {big[479:0], $random(seed)};
		{array_busy_flag_in, array_error_flag_in, verify_fail_in, total_capacity_in, capacity_addressing_flag_in,
			channel_error_code_in, linkup_in, link_speed_in, link_width_in, ltssm_state_in,
			admin_completion_code_in, io_completion_code_in, controller_capability_word_in, channel_debug_word_in,
			custom_completion_word_in, tester_status_word_in, identify_word_in, custom_data_word_in} = big[461:0];
	endtask

	// expected read word of a byte address
	function automatic logic [31:0] exp_rd(input logic [16:0] a);
		logic i;
		i = a[2];
		case (a)
			17'h00100: return {29'h0, verify_fail_in, array_error_flag_in, array_busy_flag_in};
			17'h00104: return total_capacity_in[31:0];
			17'h00108: return {capacity_addressing_flag_in, 15'h0, total_capacity_in[47:32]};
			17'h00110, 17'h00114: return channel_error_code_in[i];
			17'h00120, 17'h00124: return {15'h0, link_speed_in[i][2], 2'h0, ltssm_state_in[i], 1'h0,
				link_width_in[i], link_speed_in[i][1:0], 1'h0, linkup_in[i]};
			17'h00130, 17'h00134: return {io_completion_code_in[i], admin_completion_code_in[i]};
			17'h00140, 17'h00144: return controller_capability_word_in[i];
			17'h00150, 17'h00154: return channel_debug_word_in[i];
			default: ;
		endcase
		if (a[16:8] == 9'h005)
			return custom_completion_word_in;
		if (a[16:12] == 5'h01)
			return tester_status_word_in;
		if (a[16:15] == 2'h2)
			return identify_word_in;
		if (a[16:15] == 2'h3)
			return custom_data_word_in;
		return 32'h00000000;
	endfunction

	// read one address and compare
	task automatic rdc(input logic [16:0] a);
		i_rtf_conv_model.rd(a, got, ok);
		`CHK(ok, 1'h1)
		`CHK(got, exp_rd(a))
		`CHK(buffer_index_out, a[14:2])
	endtask

	// main sequence
	initial
	begin
		rst_in = 1'h1;
		shake();
		repeat (10) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		rst_in = 1'h0;
		// 48-bit values from two words, lane mask varied
		repeat (4)
		begin
			big[127:0] = {$random(seed), $random(seed), $random(seed), $random(seed)};
			i_rtf_conv_model.wr(17'h00000, big[31:0], 4'h0);
			i_rtf_conv_model.wr(17'h00004, big[63:32], 4'($random(seed)));
			`CHK(start_sector_out, {big[47:32], big[31:0]})
			i_rtf_conv_model.wr(17'h00008, big[95:64], 4'($random(seed)));
			i_rtf_conv_model.wr(17'h0000C, big[127:96], 4'h1);
			`CHK(sector_count_out, {big[111:96], big[95:64]})
		end
		// every command code, reserved ones included
		for (int c = 0; c < 8; c++)
		begin
			w = $random(seed);
			w[2:0] = c[2:0];
			i_rtf_conv_model.wr(17'h00010, w, 4'hF);
			`CHK(host_command_code_out, w[2:0])
			`CHK(command_request_out, 1'h1)
		end
		// every test pattern
		for (int p = 0; p < 5; p++)
		begin
			i_rtf_conv_model.wr(17'h00014, 32'(p), 4'hF);
			`CHK(pattern_select_out, p[2:0])
		end
		// timeout word, full and empty lane mask
		w = $random(seed);
		i_rtf_conv_model.wr(17'h00020, w, 4'hF);
		`CHK(command_timeout_value_out, w)
		w = $random(seed);
		i_rtf_conv_model.wr(17'h00020, w, 4'h0);
		`CHK(command_timeout_value_out, w)
		// writes to status, tester and unmapped places
		keep = start_sector_out;
		i_rtf_conv_model.wr(17'h00104, $random(seed), 4'hF);
		i_rtf_conv_model.wr(17'h00200, $random(seed), 4'hF);
		i_rtf_conv_model.wr(17'h01000, $random(seed), 4'hF);
		`CHK(start_sector_out, keep)
		// queue and data buffer writes
		i_rtf_conv_model.wr(17'h00404, w, 4'hF);
		`CHK(custom_submission_write_out, 1'h1)
		`CHK(custom_data_write_out, 1'h0)
		i_rtf_conv_model.wr(17'h1FFFC, w, 4'hF);
		`CHK(custom_data_write_out, 1'h1)
		`CHK(buffer_index_out, 13'h1FFF)
		`CHK(buffer_word_out, w)
		// status and area reads with fresh inputs each round
		repeat (3)
		begin
			@(negedge sys_clk_in);
			shake();
			rdc(17'h00100);
			rdc(17'h00104);
			rdc(17'h00108);
			rdc(17'h00110);
			rdc(17'h00114);
			rdc(17'h00120);
			rdc(17'h00124);
			rdc(17'h00130);
			rdc(17'h00134);
			rdc(17'h00144);
			rdc(17'h00150);
			rdc(17'h005FC);
			rdc(17'h01FFC);
			rdc(17'h10000);
			rdc(17'h17FFC);
			rdc(17'h18000);
			rdc(17'h00010);
			rdc(17'h00404);
			rdc(17'h0010C);
			rdc(17'h00800);
		end
		print_verdict();
	end

	// hang guard, far beyond the few hundred cycles needed
	initial
	begin
		#400000;
		num_errors++;
		print_verdict();
	end
endmodule
bind rtf_register_file rtf_register_file_chk i_rtf_register_file_chk (.sys_clk_in, .rst_in, .register_index_in,
	.write_strobe_in, .write_word_in, .read_request_pulse_in, .read_return_flag_out, .start_sector_out,
	.sector_count_out, .host_command_code_out, .command_request_out, .command_timeout_value_out,
	.custom_submission_write_out, .custom_data_write_out);
